/* src/dcfm_fifo_core.sv */
// dual-port fifo core: 64 x 36 queue, status flags, two mailbox registers
// assumes port clocks and pins are asynchronous to clk_sys_i and are sampled here
//
// Summary of operation
// - every fifo flag passes two stages clocked by its own port clock.
// - empty and almost-empty on read port; full and almost-full on write port.
// - fifo reads are ignored while empty flag is low.
// - with byte or word size, empty drops after last part is read.
// - read pointer steps once per long word moved to output register.
// - after write into empty fifo, empty rises on second read edge.
// - a read edge too close after the write is not the first sync cycle.
// - fifo writes are ignored while full flag is low.
// - write pointer steps once per accepted word.
// - after a read frees space, full rises on second write edge.
// - a write edge too close after the read is not the first sync cycle.
// - flag levels follow fill count against offset x.
// - almost-empty low at x or fewer words, high above.
// - almost-full low at 64-x or more words, high below.
// - almost-empty rises on second read edge after crossing x+1.
// - almost-full rises on second write edge after dropping below threshold.
// - fifo write needs select low, dir high, enable high, mailbox low.
// - fifo read needs select low, dir low, enable high, a size bit low.
// - write-port read with mailbox low does nothing.
// - mailbox writes: write port with mailbox high, read port with size 11.
// - writing a mail register drops its flag; writes ignored while flag low.
// - read port shows output register, or mail one when size is 11.
// - reading a mail register raises its flag on that port edge.
// - reading a mail register leaves its content unchanged.
// - reset release loads offset x from the two select pins.
// - reset clears pointers and flags; full rises two write edges later.
`timescale 1ns/10ps
module dcfm_fifo_core (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic        fifo_reset_n_i,
    input  wire logic        offset_select0_i,
    input  wire logic        offset_select1_i,
    input  wire logic        write_port_clock_i,
    input  wire logic        write_port_select_n_i,
    input  wire logic        write_port_dir_i,
    input  wire logic        write_port_enable_i,
    input  wire logic        write_port_mailbox_select_i,
    input  wire logic [35:0] write_port_bus_i,
    output logic      [35:0] write_port_bus_o,
    output logic             write_port_bus_oe_n_o,
    input  wire logic        read_port_clock_i,
    input  wire logic        read_port_select_n_i,
    input  wire logic        read_port_dir_i,
    input  wire logic        read_port_enable_i,
    input  wire logic        read_port_size_sel0_i,
    input  wire logic        read_port_size_sel1_i,
    input  wire logic [35:0] read_port_bus_i,
    output logic      [35:0] read_port_bus_o,
    output logic             read_port_bus_oe_n_o,
    output logic             full_flag_n_o,
    output logic             almost_full_flag_n_o,
    output logic             empty_flag_n_o,
    output logic             almost_empty_flag_n_o,
    output logic             mail_one_flag_n_o,
    output logic             mail_two_flag_n_o
);

    localparam int PW = dcfm_pkg::PTR_W;
    localparam int SW = 86;

    // pin synchronisers: every pin, both port clocks included, gets two flops
    logic [SW-1:0] pin_s1;
    logic [SW-1:0] pin_s2;
    logic          wclk_q;
    logic          rclk_q;
    logic          rstn_q;
    logic          wclk_s;
    logic          rclk_s;
    logic          rstn_s;
    logic          fs0_s;
    logic          fs1_s;
    logic          ws_n;
    logic          wdir;
    logic          wen;
    logic          wmb;
    logic [35:0]   wbus;
    logic          rs_n;
    logic          rdir;
    logic          ren;
    logic [1:0]    rsize;
    logic [35:0]   rbus;

    always_ff @(posedge clk_sys_i) begin
        pin_s1 <= {write_port_clock_i, read_port_clock_i, fifo_reset_n_i,
                   offset_select1_i, offset_select0_i,
                   write_port_select_n_i, write_port_dir_i, write_port_enable_i,
                   write_port_mailbox_select_i, write_port_bus_i,
                   read_port_select_n_i, read_port_dir_i, read_port_enable_i,
                   read_port_size_sel1_i, read_port_size_sel0_i, read_port_bus_i};
        pin_s2 <= pin_s1;
    end

    assign {wclk_s, rclk_s, rstn_s, fs1_s, fs0_s, ws_n, wdir, wen, wmb, wbus,
            rs_n, rdir, ren, rsize, rbus} = pin_s2;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            // start high: a clock already high at release must not look like an edge
            wclk_q <= 1'b1;
            rclk_q <= 1'b1;
            rstn_q <= 1'b0;
        end else begin
            wclk_q <= wclk_s;
            rclk_q <= rclk_s;
            rstn_q <= rstn_s;
        end
    end

    // a port edge is one system cycle; pointers it moves show from the next
    // cycle, so an edge of the other port in that same cycle cannot count
    logic w_edge;
    logic r_edge;
    logic dev_rst;

    assign w_edge  = wclk_s & ~wclk_q;
    assign r_edge  = rclk_s & ~rclk_q;
    assign dev_rst = srst_i | ~rstn_s;

    // offset register, loaded as the device reset pin goes high
    logic [PW-1:0] offset;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            offset <= dcfm_pkg::OFFSET_RST;
        end else if (rstn_s & ~rstn_q) begin
            offset <= dcfm_pkg::offset_decode(fs1_s, fs0_s);
        end
    end

    // port decode
    logic wr_fifo;
    logic wr_accept;
    logic mail_one_wr;
    logic mail_two_rd;
    logic rd_req;
    logic rd_ok;
    logic fetch;
    logic mail_two_wr;
    logic mail_one_rd;
    logic mail_one_flag_n;
    logic mail_two_flag_n;
    logic full_flag_n;
    logic empty_flag_n;

    assign wr_fifo     = w_edge & ~ws_n & wdir & wen & ~wmb;
    assign wr_accept   = wr_fifo & full_flag_n;
    assign mail_one_wr = w_edge & ~ws_n & wdir & wen & wmb & mail_one_flag_n;
    // a read with the mailbox deselected is decoded to nothing
    assign mail_two_rd = w_edge & ~ws_n & ~wdir & wen & wmb;

    assign rd_req      = r_edge & ~rs_n & ~rdir & ren & (rsize != dcfm_pkg::SIZE_MAIL);
    assign rd_ok       = rd_req & empty_flag_n;
    assign mail_two_wr = r_edge & ~rs_n & rdir & ren & (rsize == dcfm_pkg::SIZE_MAIL)
                         & mail_two_flag_n;
    assign mail_one_rd = r_edge & ~rs_n & ~rdir & ren & (rsize == dcfm_pkg::SIZE_MAIL);

    // write side pointers
    logic [PW-1:0] wptr;
    logic [PW-1:0] wptr_gray;
    logic [PW-1:0] rptr_gray_w1;
    logic [PW-1:0] rptr_gray;
    logic [PW-1:0] next_wptr;
    logic [PW-1:0] wfill;
    logic          w_seen;

    assign next_wptr = wptr + {{(PW-1){1'b0}}, wr_accept};
    assign wfill     = next_wptr - dcfm_pkg::gray2bin(rptr_gray_w1);

    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            wptr      <= '0;
            wptr_gray <= '0;
        end else begin
            wptr      <= next_wptr;
            wptr_gray <= dcfm_pkg::bin2gray(next_wptr);
        end
    end

    // first write-side stage holds the read pointer, the flag flop is the second
    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            rptr_gray_w1         <= '0;
            w_seen               <= 1'b0;
            full_flag_n          <= 1'b0;
            almost_full_flag_n_o <= 1'b1;
        end else if (w_edge) begin
            rptr_gray_w1         <= rptr_gray;
            w_seen               <= 1'b1;
            // w_seen keeps full low through the first edge after reset
            full_flag_n          <= w_seen & (wfill != dcfm_pkg::FILL_FULL);
            almost_full_flag_n_o <= wfill < (dcfm_pkg::FILL_FULL - offset);
        end
    end

    assign full_flag_n_o = full_flag_n;

    // read side pointers
    logic [PW-1:0] rptr;
    logic [PW-1:0] wptr_gray_r1;
    logic [PW-1:0] next_rptr;
    logic [PW-1:0] rfill;
    logic [1:0]    parts_left;
    logic [1:0]    next_parts;

    // a new long word leaves memory only when no part of the last one is owed
    assign fetch     = rd_ok & (parts_left == 2'd0);
    assign next_rptr = rptr + {{(PW-1){1'b0}}, fetch};
    assign rfill     = dcfm_pkg::gray2bin(wptr_gray_r1) - next_rptr;

    always_comb begin
        next_parts = parts_left;
        if (fetch) begin
            next_parts = dcfm_pkg::parts_for(rsize);
        end else if (rd_ok) begin
            next_parts = parts_left - 2'd1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            rptr       <= '0;
            rptr_gray  <= '0;
            parts_left <= 2'd0;
        end else begin
            rptr       <= next_rptr;
            rptr_gray  <= dcfm_pkg::bin2gray(next_rptr);
            parts_left <= next_parts;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            wptr_gray_r1          <= '0;
            empty_flag_n          <= 1'b0;
            almost_empty_flag_n_o <= 1'b0;
        end else if (r_edge) begin
            wptr_gray_r1          <= wptr_gray;
            // owed parts keep the flag high until the last of them is read
            empty_flag_n          <= (rfill != dcfm_pkg::FILL_NONE)
                                     | (next_parts != 2'd0);
            almost_empty_flag_n_o <= rfill > offset;
        end
    end

    assign empty_flag_n_o = empty_flag_n;

    // storage; its read register is the fifo output register
    logic [35:0] fifo_out;

    dcfm_mem u_mem (
        .clk_sys_i (clk_sys_i),
        .we_i      (wr_accept),
        .waddr_i   (wptr[dcfm_pkg::ADDR_W-1:0]),
        .wdata_i   (wbus),
        .re_i      (fetch),
        .raddr_i   (rptr[dcfm_pkg::ADDR_W-1:0]),
        .rdata_o   (fifo_out)
    );

    // mailboxes: a write in the same cycle as a read leaves the flag low
    logic [35:0] mail_one_reg;
    logic [35:0] mail_two_reg;

    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            mail_one_flag_n <= 1'b1;
        end else if (mail_one_wr) begin
            mail_one_flag_n <= 1'b0;
        end else if (mail_one_rd) begin
            mail_one_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (dev_rst) begin
            mail_two_flag_n <= 1'b1;
        end else if (mail_two_wr) begin
            mail_two_flag_n <= 1'b0;
        end else if (mail_two_rd) begin
            mail_two_flag_n <= 1'b1;
        end
    end

    // content survives reads and the device reset pin; srst_i clears it, otherwise only a write replaces it
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mail_one_reg <= dcfm_pkg::DATA_RST;
            mail_two_reg <= dcfm_pkg::DATA_RST;
        end else begin
            if (mail_one_wr) begin
                mail_one_reg <= wbus;
            end
            if (mail_two_wr) begin
                mail_two_reg <= rbus;
            end
        end
    end

    assign mail_one_flag_n_o = mail_one_flag_n;
    assign mail_two_flag_n_o = mail_two_flag_n;

    // bus drivers, one system cycle behind the sampled controls
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            read_port_bus_o       <= dcfm_pkg::DATA_RST;
            read_port_bus_oe_n_o  <= 1'b1;
            write_port_bus_o      <= dcfm_pkg::DATA_RST;
            write_port_bus_oe_n_o <= 1'b1;
        end else begin
            read_port_bus_o       <= (rsize == dcfm_pkg::SIZE_MAIL) ? mail_one_reg
                                                                    : fifo_out;
            read_port_bus_oe_n_o  <= rs_n | rdir;
            write_port_bus_o      <= mail_two_reg;
            write_port_bus_oe_n_o <= ws_n | wdir;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (dev_rst);

    sequence s_write_into_empty;
        wr_accept && !empty_flag_n && (parts_left == 2'd0);
    endsequence

    sequence s_empty_held;
        !empty_flag_n [*2];
    endsequence

    property p_empty_sync;
        s_write_into_empty |=> s_empty_held;
    endproperty
    a_empty_sync: assert property (p_empty_sync) else $error("empty rose too soon");

    property p_read_ignored;
        rd_req && !empty_flag_n |=> $stable(rptr) && $stable(fifo_out);
    endproperty
    a_read_ignored: assert property (p_read_ignored) else $error("read taken while empty");

    property p_rptr_step;
        fetch |=> rptr == $past(rptr) + 7'd1;
    endproperty
    a_rptr_step: assert property (p_rptr_step) else $error("read pointer step wrong");

    property p_wptr_step;
        wr_accept |=> wptr == $past(wptr) + 7'd1;
    endproperty
    a_wptr_step: assert property (p_wptr_step) else $error("write pointer step wrong");

    property p_write_ignored;
        wr_fifo && !full_flag_n |=> $stable(wptr);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write taken while full");

    property p_empty_domain;
        $changed(empty_flag_n) |-> $past(r_edge);
    endproperty
    a_empty_domain: assert property (p_empty_domain) else $error("empty moved off read edge");

    property p_full_domain;
        $changed(full_flag_n) |-> $past(w_edge);
    endproperty
    a_full_domain: assert property (p_full_domain) else $error("full moved off write edge");

    property p_mail_lock;
        w_edge && !ws_n && wdir && wen && wmb && !mail_one_flag_n && !mail_one_rd
            |=> $stable(mail_one_reg) && !mail_one_flag_n;
    endproperty
    a_mail_lock: assert property (p_mail_lock) else $error("mail one overwritten");

    property p_mail_release;
        mail_one_rd && !mail_one_wr |=> mail_one_flag_n && $stable(mail_one_reg);
    endproperty
    a_mail_release: assert property (p_mail_release) else $error("mail one read wrong");

    property p_reset_flags;
        disable iff (1'b0)
        srst_i |=> !full_flag_n && !empty_flag_n && almost_full_flag_n_o
                   && mail_one_flag_n && mail_two_flag_n;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("reset flag values wrong");

endmodule

/* src/dcfm_pkg.sv */
// constants, encodings and pointer helpers for the dual-port fifo core
// assumes one system clock samples both port clocks and all port pins
package dcfm_pkg;

    localparam int DATA_W = 36;
    localparam int ADDR_W = 6;
    localparam int PTR_W  = 7;

    // fill level of a full memory, as seen by a pointer difference
    localparam logic [PTR_W-1:0] FILL_FULL = 7'h40;
    localparam logic [PTR_W-1:0] FILL_NONE = 7'h00;

    // offset presets chosen by the two select pins when reset releases
    localparam logic [PTR_W-1:0] OFFSET_SEL_HH = 7'h10;
    localparam logic [PTR_W-1:0] OFFSET_SEL_HL = 7'h0c;
    localparam logic [PTR_W-1:0] OFFSET_SEL_LH = 7'h08;
    localparam logic [PTR_W-1:0] OFFSET_SEL_LL = 7'h04;
    localparam logic [PTR_W-1:0] OFFSET_RST    = 7'h04;

    // read size code {size_sel1, size_sel0}
    localparam logic [1:0] SIZE_LONG = 2'b00;
    localparam logic [1:0] SIZE_WORD = 2'b01;
    localparam logic [1:0] SIZE_BYTE = 2'b10;
    localparam logic [1:0] SIZE_MAIL = 2'b11;

    // further reads still owed from one long word after it is fetched
    localparam logic [1:0] PARTS_LONG = 2'd0;
    localparam logic [1:0] PARTS_WORD = 2'd1;
    localparam logic [1:0] PARTS_BYTE = 2'd3;

    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction

    function automatic logic [PTR_W-1:0] offset_decode(input logic fs1, input logic fs0);
        case ({fs1, fs0})
            2'b11:   return OFFSET_SEL_HH;
            2'b10:   return OFFSET_SEL_HL;
            2'b01:   return OFFSET_SEL_LH;
            default: return OFFSET_SEL_LL;
        endcase
    endfunction

    function automatic logic [1:0] parts_for(input logic [1:0] size);
        case (size)
            SIZE_WORD: return PARTS_WORD;
            SIZE_BYTE: return PARTS_BYTE;
            default:   return PARTS_LONG;
        endcase
    endfunction

endpackage

/* src/dcfm_mem.sv */
// 64 x 36 storage array with a registered read port
// the read register doubles as the fifo output register; it holds while re is low
`timescale 1ns/10ps
module dcfm_mem (
    input  wire logic                          clk_sys_i,
    input  wire logic                          we_i,
    input  wire logic [dcfm_pkg::ADDR_W-1:0]   waddr_i,
    input  wire logic [dcfm_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                          re_i,
    input  wire logic [dcfm_pkg::ADDR_W-1:0]   raddr_i,
    output logic      [dcfm_pkg::DATA_W-1:0]   rdata_o
);

    logic [dcfm_pkg::DATA_W-1:0] mem [0:(1 << dcfm_pkg::ADDR_W)-1];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

/* tb/dcfm_port_model.sv */
// far-side bus masters of both fifo ports, each with its own free-running port clock
// assumes the bench calls the tasks hierarchically, one request at a time per port
`timescale 1ns/10ps
module dcfm_port_model (
    output logic        wclk_o,
    output logic        w_sel_n_o,
    output logic        w_dir_o,
    output logic        w_en_o,
    output logic        w_mb_o,
    output logic [35:0] w_bus_o,
    output logic        rclk_o,
    output logic        r_sel_n_o,
    output logic        r_dir_o,
    output logic        r_en_o,
    output logic [1:0]  r_size_o,
    output logic [35:0] r_bus_o
);
    // odd phase offset keeps the two port clocks unrelated
    initial begin
        {w_sel_n_o, w_dir_o, w_en_o, w_mb_o, w_bus_o} = {4'h8, 36'h0};
        {r_sel_n_o, r_dir_o, r_en_o, r_size_o, r_bus_o} = {5'h10, 36'h0};
        wclk_o = 1'b0;
        rclk_o = 1'b0;
        fork
            forever #80 wclk_o = ~wclk_o;
            #53 forever #80 rclk_o = ~rclk_o;
        join
    end
    // request set up at the falling edge, held through the sampling rising edge
    task automatic wp_go(input logic dir, input logic mb, input logic [35:0] d);
        @(negedge wclk_o);
        {w_sel_n_o, w_dir_o, w_en_o, w_mb_o, w_bus_o} = {1'b0, dir, 1'b1, mb, d};
        @(posedge wclk_o);
    endtask
    // a released bus shows the inverse, so a stale value never passes for fresh
    task automatic wp_end();
        @(negedge wclk_o);
        {w_sel_n_o, w_en_o} = 2'b10;
        w_bus_o = ~w_bus_o;
    endtask
    task automatic wp(input logic dir, input logic mb, input logic [35:0] d);
        wp_go(dir, mb, d);
        wp_end();
    endtask
    task automatic rp_go(input logic dir, input logic [1:0] s, input logic [35:0] d);
        @(negedge rclk_o);
        {r_sel_n_o, r_dir_o, r_en_o, r_size_o, r_bus_o} = {1'b0, dir, 1'b1, s, d};
        @(posedge rclk_o);
    endtask
    task automatic rp_end();
        @(negedge rclk_o);
        {r_sel_n_o, r_en_o} = 2'b10;
        r_bus_o = ~r_bus_o;
    endtask
    task automatic rp(input logic dir, input logic [1:0] s, input logic [35:0] d);
        rp_go(dir, s, d);
        rp_end();
    endtask
endmodule

/* tb/dcfm_fifo_core_tb.sv */
// self-checking bench for the dual-port fifo core and its mailboxes
// assumes dcfm_port_model drives both ports; flags are checked once settled
`timescale 1ns/10ps
module dcfm_fifo_core_tb;
    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        rst_n = 1'b0;
    logic [1:0]  fs = 2'b00;
    logic [1:0]  mf = 2'b11;
    logic        wclk, wsn, wdir, wen, wmb, rclk, rsn, rdir, ren, w_oe_n, r_oe_n;
    logic [1:0]  rsz;
    logic [35:0] wbi, wbo, rbi, rbo;
    wire  [5:0]  fl;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          i;
    int          x;

    dcfm_fifo_core u_dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .fifo_reset_n_i(rst_n),
        .offset_select0_i(fs[0]), .offset_select1_i(fs[1]),
        .write_port_clock_i(wclk), .write_port_select_n_i(wsn),
        .write_port_dir_i(wdir), .write_port_enable_i(wen),
        .write_port_mailbox_select_i(wmb), .write_port_bus_i(wbi),
        .write_port_bus_o(wbo), .write_port_bus_oe_n_o(w_oe_n),
        .read_port_clock_i(rclk), .read_port_select_n_i(rsn),
        .read_port_dir_i(rdir), .read_port_enable_i(ren),
        .read_port_size_sel0_i(rsz[0]), .read_port_size_sel1_i(rsz[1]),
        .read_port_bus_i(rbi), .read_port_bus_o(rbo), .read_port_bus_oe_n_o(r_oe_n),
        .full_flag_n_o(fl[5]), .almost_full_flag_n_o(fl[4]),
        .empty_flag_n_o(fl[3]), .almost_empty_flag_n_o(fl[2]),
        .mail_one_flag_n_o(fl[1]), .mail_two_flag_n_o(fl[0])
    );
    dcfm_port_model u_far (
        .wclk_o(wclk), .w_sel_n_o(wsn), .w_dir_o(wdir), .w_en_o(wen), .w_mb_o(wmb),
        .w_bus_o(wbi), .rclk_o(rclk), .r_sel_n_o(rsn), .r_dir_o(rdir), .r_en_o(ren),
        .r_size_o(rsz), .r_bus_o(rbi)
    );

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // ceiling is several times the expected run length
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chkf(input logic [5:0] e);
        total_checks++;
        if (fl !== e) begin
            err_total++;
            $display("ERROR %0t flags %b exp %b", $time, fl, e);
        end
    endtask
    task automatic chkd(input logic [35:0] g, input logic [35:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t data %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkn(input int g, input int lo);
        total_checks++;
        if (g < lo || g > lo + 1) begin
            err_total++;
            $display("ERROR %0t port edges %0d exp %0d", $time, g, lo);
        end
    endtask
    // flags {full, almost full, empty, almost empty, mail one, mail two}
    function automatic logic [5:0] expf(input int f, input int xo, input logic [1:0] m);
        return {f != 64, f < 64 - xo, f != 0, f > xo, m};
    endfunction
    function automatic logic [35:0] dw(input int k);
        return 36'h5_a5a5_0000 + 36'(k);
    endfunction
    task automatic settle();
        repeat (4) @(posedge rclk);
        #120;
    endtask
    // one extra edge allowed when the first lands inside the skew interval
    task automatic edges(input logic r, input int b, input int lo);
        int k;
        k = 0;
        while (k < 6 && fl[b] !== 1'b1) begin
            if (r) begin
                @(posedge rclk);
            end else begin
                @(posedge wclk);
            end
            k++;
            #120;
        end
        chkn(k, lo);
    endtask
    task automatic wr(input int k);
        u_far.wp(1'b1, 1'b0, dw(k));
    endtask
    task automatic rd(input logic [1:0] s);
        u_far.rp(1'b0, s, 36'h0);
        #40;
    endtask
    task automatic dev_reset(input logic [1:0] c);
        @(posedge clk_sys_i);
        #2;
        rst_n = 1'b0;
        fs = c;
        repeat (5) @(posedge rclk);
        @(posedge clk_sys_i);
        #2;
        chkf(6'h13);
        rst_n = 1'b1;
        edges(1'b0, 5, 2);
    endtask

    // offset presets and the almost-empty threshold for each select code
    task automatic sc_offsets();
        for (int c = 0; c < 4; c++) begin
            dev_reset(c[1:0]);
            x = 4 * (c + 1);
            for (i = 0; i < x; i++) wr(i);
            settle();
            chkf(expf(x, x, mf));
            wr(x);
            settle();
            chkf(expf(x + 1, x, mf));
        end
    endtask
    // fill to the top, then a refused write and an idle write-port read
    task automatic sc_fill();
        for (i = 17; i < 64; i++) begin
            wr(i);
            if (i == 46 || i == 47 || i == 62 || i == 63) begin
                settle();
                chkf(expf(i + 1, 16, mf));
            end
        end
        wr(99);
        u_far.wp(1'b0, 1'b0, 36'h0);
        settle();
        chkf(expf(64, 16, mf));
    endtask
    // drain in long words, full and almost-full recovery
    task automatic sc_drain();
        u_far.rp_go(1'b0, dcfm_pkg::SIZE_LONG, 36'h0);
        fork
            u_far.rp_end();
        join_none
        edges(1'b0, 5, 2);
        chkd(rbo, dw(0));
        for (i = 1; i < 64; i++) begin
            rd(dcfm_pkg::SIZE_LONG);
            chkd(rbo, dw(i));
            if (i == 15 || i == 16) begin
                settle();
                chkf(expf(63 - i, 16, mf));
            end
        end
        settle();
        chkf(expf(0, 16, mf));
        rd(dcfm_pkg::SIZE_LONG);
        chkd(rbo, dw(63));
    endtask
    // write into an empty fifo and count read edges until empty rises
    task automatic sc_empty_sync();
        u_far.wp_go(1'b1, 1'b0, dw(70));
        fork
            u_far.wp_end();
        join_none
        edges(1'b1, 3, 2);
        rd(dcfm_pkg::SIZE_LONG);
        chkd(rbo, dw(70));
    endtask
    // byte and word reads keep empty high until the last part
    task automatic sc_sizing();
        for (int s = 0; s < 2; s++) begin
            wr(80 + s);
            settle();
            rd(s ? dcfm_pkg::SIZE_WORD : dcfm_pkg::SIZE_BYTE);
            chkd(rbo, dw(80 + s));
            settle();
            chkf(expf(1, 16, mf));
            repeat (s ? 1 : 3) rd(s ? dcfm_pkg::SIZE_WORD : dcfm_pkg::SIZE_BYTE);
            settle();
            chkf(expf(0, 16, mf));
        end
    endtask
    // mail one: write port to read port
    task automatic sc_mail_one();
        u_far.wp(1'b1, 1'b1, 36'h1_2345_6789);
        u_far.wp(1'b1, 1'b1, 36'h9_8765_4321);
        settle();
        mf = 2'b01;
        chkf(expf(0, 16, mf));
        repeat (2) begin
            rd(dcfm_pkg::SIZE_MAIL);
            chkd(rbo, 36'h1_2345_6789);
        end
        mf = 2'b11;
        chkf(expf(0, 16, mf));
    endtask
    // mail two: read port to write port, then both bus enables
    task automatic sc_mail_two();
        u_far.rp(1'b1, dcfm_pkg::SIZE_MAIL, 36'h3_0f0f_0f0f);
        u_far.rp(1'b1, dcfm_pkg::SIZE_MAIL, 36'hc_f0f0_f0f0);
        settle();
        mf = 2'b10;
        chkf(expf(0, 16, mf));
        u_far.wp_go(1'b0, 1'b1, 36'h0);
        #60;
        chkd(wbo, 36'h3_0f0f_0f0f);
        chkd({35'h0, w_oe_n}, 36'h0);
        u_far.wp_end();
        settle();
        mf = 2'b11;
        chkf(expf(0, 16, mf));
        u_far.rp_go(1'b0, dcfm_pkg::SIZE_MAIL, 36'h0);
        #60;
        chkd(rbo, 36'h1_2345_6789);
        chkd({35'h0, r_oe_n}, 36'h0);
        u_far.rp_end();
        settle();
        chkd({34'h0, r_oe_n, w_oe_n}, 36'h3);
        chkf(expf(0, 16, mf));
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #2;
        srst_i = 1'b0;
        sc_offsets();
        sc_fill();
        sc_drain();
        sc_empty_sync();
        sc_sizing();
        sc_mail_one();
        sc_mail_two();
        results();
    end
endmodule
